// file: src/mbp_device_end.sv
// module: memory package end, flash die and psram die behind the shared pins
`default_nettype none

module mbp_device_end (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // board level acceleration pin
  input wire logic [1:0] i_vpp_level,
  // status
  output logic o_flash_busy,
  output logic o_unlock_bypass,
  output logic [15:0] o_flash_cfg,
  output logic [15:0] o_psram_cfg,
  // pins
  mbp_bus_if.dev bus
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic bclk_s;
  logic bclk_d_q;
  logic bclk_rise;
  logic [1:0] vpp_s;
  logic frst_n;
  logic sel_flash;
  logic sel_psram;
  logic sel_any;
  logic [15:0] cfg;
  logic async_mode;
  logic [23:0] full_addr;
  logic [23:0] addr_q;
  logic [1:0] lat_q;
  logic bvalid_q;
  logic data_valid;
  logic flash_level;
  logic psram_level;
  logic we_n_q;
  logic wr_strobe;
  logic fwr;
  logic pwr;
  logic cfg_hit;
  logic [15:0] fcfg_q;
  logic [15:0] bcr_q;
  logic [3:0] busy_q;
  logic ubyp_q;
  logic [15:0] dout_q;
  logic [15:0] din;
  logic [mbp_pkg::MEM_IDX_W-1:0] idx;
  logic [15:0] fmem [mbp_pkg::MEM_DEPTH];
  logic [15:0] pmem [mbp_pkg::MEM_DEPTH];

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  // the burst clock is only sampled, so it must stay far below i_clk / 2
  mbp_sync #(
    .W(1),
    .RST(1'b0)
  ) u_bclk_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(bus.burst_clk),
    .o_sync(bclk_s)
  );

  mbp_sync #(
    .W(2),
    .RST(mbp_pkg::VPP_NORM)
  ) u_vpp_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_vpp_level),
    .o_sync(vpp_s)
  );

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bclk_d_q <= 1'b0;
    end else begin
      bclk_d_q <= bclk_s;
    end
  end

  assign bclk_rise = bclk_s & ~bclk_d_q;

  // ----------------------------------------
  // die selection
  // ----------------------------------------
  // flash wins if the host enables both dies at once
  assign frst_n = bus.flash_rst_n;
  assign sel_flash = ~bus.flash_ce_n & frst_n;
  assign sel_psram = ~bus.psram_ce_n & bus.flash_ce_n;
  assign sel_any = sel_flash | sel_psram;
  assign cfg = sel_flash ? fcfg_q : bcr_q;
  assign async_mode = cfg[mbp_pkg::CFG_ASYNC_BIT];
  assign full_addr = {bus.upper_addr_inputs, bus.shared_addr_data_bus};
  assign idx = addr_q[mbp_pkg::MEM_IDX_W-1:0];
  assign din = bus.shared_addr_data_bus;

  // ----------------------------------------
  // address capture and burst counter
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_q <= 24'h000000;
      lat_q <= 2'h0;
      bvalid_q <= 1'b0;
    end else if (!sel_any) begin
      // deselect, or flash reset pin low on a flash access, drops the burst at once
      lat_q <= 2'h0;
      bvalid_q <= 1'b0;
    end else if (!bus.addr_valid_n) begin
      if (async_mode) begin
        addr_q <= full_addr;
      end else if (bclk_rise) begin
        addr_q <= full_addr;
      end
      lat_q <= 2'h0;
      bvalid_q <= 1'b0;
    end else if (!async_mode && bclk_rise && bus.we_n) begin
      // strobe high: pins are no longer looked at, only the counter moves
      if (bvalid_q) begin
        addr_q <= addr_q + 24'h000001;
      end else if (lat_q == mbp_pkg::BURST_LAT - 2'h1) begin
        bvalid_q <= 1'b1;
      end else begin
        lat_q <= lat_q + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dout_q <= 16'h0000;
    end else if (sel_flash) begin
      dout_q <= fmem[idx];
    end else begin
      dout_q <= pmem[idx];
    end
  end

  // drive follows output and chip enables directly, no burst clock edge needed
  // bus only driven after the strobe has gone high and the host turned around
  assign bus.dev_dq_oe = sel_any & ~bus.oe_n & bus.addr_valid_n & bus.we_n;
  assign bus.dev_dq_o = dout_q;

  // ----------------------------------------
  // ready / wait line
  // ----------------------------------------
  // async accesses never hold the host off
  assign data_valid = async_mode | bvalid_q;
  // bit 10 set: high when valid; cleared: low when valid
  assign flash_level = ~(data_valid ^ fcfg_q[mbp_pkg::CFG_POL_BIT]);
  // bit 10 set: high while invalid; cleared: active low wait
  assign psram_level = data_valid ^ bcr_q[mbp_pkg::CFG_POL_BIT];
  assign bus.rdy_o = sel_flash ? flash_level : psram_level;
  assign bus.rdy_oe = sel_any;

  // ----------------------------------------
  // write strobe
  // ----------------------------------------
  // a write lands on the rising edge of the write enable
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      we_n_q <= 1'b1;
    end else begin
      we_n_q <= bus.we_n;
    end
  end

  assign wr_strobe = sel_any & bus.addr_valid_n & ~we_n_q & bus.we_n;
  assign fwr = wr_strobe & sel_flash;
  assign pwr = wr_strobe & sel_psram;
  assign cfg_hit = addr_q == mbp_pkg::FCFG_ADDR;

  // ----------------------------------------
  // psram die
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bcr_q <= mbp_pkg::BCR_RST;
    end else if (pwr && bus.psram_ctrl_reg_select) begin
      bcr_q <= din;
    end
  end

  // array has no reset: contents are undefined until written
  always_ff @(posedge i_clk) begin
    if (pwr && !bus.psram_ctrl_reg_select) begin
      if (!bus.psram_low_byte_n) begin
        pmem[idx][7:0] <= din[7:0];
      end
      if (!bus.psram_high_byte_n) begin
        pmem[idx][15:8] <= din[15:8];
      end
    end
  end

  // ----------------------------------------
  // flash die
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fcfg_q <= mbp_pkg::FCFG_RST;
      busy_q <= 4'h0;
      ubyp_q <= 1'b0;
    end else if (!frst_n) begin
      // aborts programming and returns to array read
      fcfg_q <= mbp_pkg::FCFG_RST;
      busy_q <= 4'h0;
      ubyp_q <= 1'b0;
    end else begin
      ubyp_q <= vpp_s == mbp_pkg::VPP_HH;
      if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
      end else if (fwr && cfg_hit) begin
        fcfg_q <= din;
      end else if (fwr && vpp_s != mbp_pkg::VPP_LOW) begin
        // a low acceleration pin refuses the program outright
        busy_q <= (vpp_s == mbp_pkg::VPP_HH) ? mbp_pkg::ACC_PROG_CYC : mbp_pkg::PROG_CYC;
      end
    end
  end

  // writes while busy are dropped, the host sees this on the busy output
  always_ff @(posedge i_clk) begin
    if (fwr && !cfg_hit && busy_q == 4'h0 && vpp_s != mbp_pkg::VPP_LOW) begin
      fmem[idx] <= din;
    end
  end

  // ----------------------------------------
  // status
  // ----------------------------------------
  assign o_flash_busy = busy_q != 4'h0;
  assign o_unlock_bypass = ubyp_q;
  assign o_flash_cfg = fcfg_q;
  assign o_psram_cfg = bcr_q;
endmodule : mbp_device_end

`default_nettype wire

// file: src/mbp_pkg.sv
// package: constants and types shared by both ends of the muxed burst pin interface
// Operation
// - async mode: strobe low marks a valid address
// - burst mode: start address captured while strobe low
// - strobe high: address inputs are ignored
// - after first burst word, each edge advances address
// - host keeps burst clock steady in async mode
// - flash ready: default high means data valid
// - psram wait default: low valid, high invalid
// - psram config bit 10 cleared: wait active low
// - flash config bit 10 cleared: ready active low
// - flash reset pin low returns flash to array read
// - output enable acts without waiting on burst clock
// - flash chip enable acts without the burst clock
// - acceleration low blocks programming, high level accelerates
// - burst clock never above 108 MHz
`default_nettype none

package mbp_pkg;
  // ----------------------------------------
  // widths and storage
  // ----------------------------------------
  localparam int DQ_W = 16;
  localparam int UA_W = 8;
  localparam int ADDR_W = 24;
  localparam int MEM_IDX_W = 4;
  localparam int MEM_DEPTH = 16;

  // ----------------------------------------
  // configuration words
  // ----------------------------------------
  localparam logic [15:0] FCFG_RST = 16'h8400;
  localparam logic [15:0] BCR_RST = 16'h8400;
  localparam int CFG_ASYNC_BIT = 15;
  localparam int CFG_POL_BIT = 10;
  localparam logic [23:0] FCFG_ADDR = 24'hFF0000;

  // ----------------------------------------
  // cycle counts
  // ----------------------------------------
  localparam logic [1:0] BURST_LAT = 2'h2;
  localparam logic [3:0] PROG_CYC = 4'h8;
  localparam logic [3:0] ACC_PROG_CYC = 4'h2;
  localparam logic [2:0] BCLK_HALF = 3'h4;
  localparam logic [2:0] BCLK_LAST = BCLK_HALF - 3'h1;
  localparam logic [3:0] ADDR_CYC = 4'h2;
  localparam logic [3:0] RD_CYC = 4'h4;
  localparam logic [3:0] WR_CYC = 4'h3;
  localparam int CLK_HZ = 10_000_000;
  localparam int BURST_MAX_HZ = 108_000_000;
  localparam int BCLK_HZ = CLK_HZ / (2 * 4);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    VPP_LOW = 2'h0,
    VPP_NORM = 2'h1,
    VPP_HH = 2'h2
  } mbp_vpp_type;

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_ADDR = 6'h02,
    H_TURN = 6'h04,
    H_RD = 6'h08,
    H_WR = 6'h10,
    H_END = 6'h20
  } mbp_hst_type;
endpackage : mbp_pkg

`default_nettype wire

// file: src/mbp_bus_if.sv
// interface: the shared pins between memory controller and memory package
`default_nettype none

interface mbp_bus_if;
  logic addr_valid_n;
  logic [mbp_pkg::UA_W-1:0] upper_addr_inputs;
  logic [mbp_pkg::DQ_W-1:0] host_dq_o;
  logic host_dq_oe;
  logic [mbp_pkg::DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic [mbp_pkg::DQ_W-1:0] shared_addr_data_bus;
  logic burst_clk;
  logic oe_n;
  logic we_n;
  logic flash_ce_n;
  logic psram_ce_n;
  logic flash_rst_n;
  logic psram_ctrl_reg_select;
  logic psram_low_byte_n;
  logic psram_high_byte_n;
  logic rdy_o;
  logic rdy_oe;
  logic rdy_wait;

  // ----------------------------------------
  // wire resolution
  // ----------------------------------------
  // host wins a clash so a contention shows as host data, not a mix
  assign shared_addr_data_bus = host_dq_oe ? host_dq_o : (dev_dq_oe ? dev_dq_o : '0);
  // idle ready line floats high through its pull-up
  assign rdy_wait = rdy_oe ? rdy_o : 1'b1;

  modport dev (
    input addr_valid_n, upper_addr_inputs, shared_addr_data_bus, burst_clk,
    input oe_n, we_n, flash_ce_n, psram_ce_n, flash_rst_n,
    input psram_ctrl_reg_select, psram_low_byte_n, psram_high_byte_n,
    output dev_dq_o, dev_dq_oe, rdy_o, rdy_oe
  );

  modport host (
    output addr_valid_n, upper_addr_inputs, host_dq_o, host_dq_oe, burst_clk,
    output oe_n, we_n, flash_ce_n, psram_ce_n, flash_rst_n,
    output psram_ctrl_reg_select, psram_low_byte_n, psram_high_byte_n,
    input shared_addr_data_bus, rdy_wait
  );
endinterface : mbp_bus_if

`default_nettype wire

// file: src/mbp_sync.sv
// module: two flip-flop synchroniser for pin levels
`default_nettype none

module mbp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= RST;
      o_sync <= RST;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : mbp_sync

`default_nettype wire

// file: src/mbp_host_end.sv
// module: memory controller end driving the shared burst pins
`default_nettype none

module mbp_host_end (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // request
  input wire logic i_req,
  input wire logic i_write,
  input wire logic i_psram,
  input wire logic i_burst,
  input wire logic [3:0] i_len,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_ctrl_reg,
  input wire logic [1:0] i_byte_en_n,
  // configuration
  input wire logic i_flash_reset,
  input wire logic i_flash_rdy_low,
  input wire logic i_psram_wait_low,
  // answer
  output logic o_busy,
  output logic o_rvalid,
  output logic [15:0] o_rdata,
  output logic o_done,
  // pins
  mbp_bus_if.host bus
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  mbp_pkg::mbp_hst_type st_q;
  logic [3:0] cnt_q;
  logic [3:0] got_q;
  logic [3:0] len_q;
  logic [23:0] addr_q;
  logic [15:0] wdata_q;
  logic write_q;
  logic psram_q;
  logic burst_q;
  logic cre_q;
  logic [1:0] ben_n_q;
  logic frst_q;
  logic [2:0] div_q;
  logic bclk_q;
  logic run;
  logic bclk_rise;
  logic bclk_fall;
  logic line_valid;
  logic rd_take;
  logic active;

  // ----------------------------------------
  // burst clock divider
  // ----------------------------------------
  // i_clk / 8 keeps the burst clock far under its ceiling
  assign run = burst_q & (st_q == mbp_pkg::H_ADDR | st_q == mbp_pkg::H_TURN |
                          st_q == mbp_pkg::H_RD);
  assign bclk_rise = run & ~bclk_q & (div_q == mbp_pkg::BCLK_LAST);
  assign bclk_fall = run & bclk_q & (div_q == mbp_pkg::BCLK_LAST);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_q <= 3'h0;
      bclk_q <= 1'b0;
    end else if (!run) begin
      div_q <= 3'h0;
      bclk_q <= 1'b0;
    end else if (div_q == mbp_pkg::BCLK_LAST) begin
      div_q <= 3'h0;
      bclk_q <= ~bclk_q;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // polarity inputs must match what was written to each die's bit 10
  assign line_valid = psram_q ? (bus.rdy_wait == i_psram_wait_low) :
                                (bus.rdy_wait != i_flash_rdy_low);
  assign rd_take = (st_q == mbp_pkg::H_RD) &
                   (burst_q ? (bclk_rise & line_valid) : (cnt_q == mbp_pkg::RD_CYC - 4'h1));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= mbp_pkg::H_IDLE;
      cnt_q <= 4'h0;
      got_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      unique case (st_q)
        mbp_pkg::H_IDLE: begin
          cnt_q <= 4'h0;
          got_q <= 4'h0;
          if (i_req) begin
            st_q <= mbp_pkg::H_ADDR;
          end
        end
        mbp_pkg::H_ADDR: begin
          // burst holds the strobe through a whole burst clock period
          if (burst_q ? bclk_fall : (cnt_q == mbp_pkg::ADDR_CYC - 4'h1)) begin
            st_q <= write_q ? mbp_pkg::H_WR : mbp_pkg::H_TURN;
            cnt_q <= 4'h0;
          end
        end
        mbp_pkg::H_TURN: begin
          st_q <= mbp_pkg::H_RD;
          cnt_q <= 4'h0;
        end
        mbp_pkg::H_RD: begin
          if (rd_take) begin
            got_q <= got_q + 4'h1;
            if (got_q == len_q) begin
              st_q <= mbp_pkg::H_END;
            end
          end
        end
        mbp_pkg::H_WR: begin
          if (cnt_q == mbp_pkg::WR_CYC - 4'h1) begin
            st_q <= mbp_pkg::H_END;
          end
        end
        mbp_pkg::H_END: begin
          st_q <= mbp_pkg::H_IDLE;
        end
        default: begin
          st_q <= mbp_pkg::H_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // request capture and answer
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_q <= 24'h000000;
      wdata_q <= 16'h0000;
      len_q <= 4'h0;
      write_q <= 1'b0;
      psram_q <= 1'b0;
      burst_q <= 1'b0;
      cre_q <= 1'b0;
      ben_n_q <= 2'h3;
    end else if (st_q == mbp_pkg::H_IDLE && i_req) begin
      addr_q <= i_addr;
      wdata_q <= i_wdata;
      // writes always go single word, asynchronous
      len_q <= i_write ? 4'h0 : i_len;
      write_q <= i_write;
      psram_q <= i_psram;
      burst_q <= i_burst & ~i_write;
      cre_q <= i_ctrl_reg & i_psram;
      ben_n_q <= i_byte_en_n;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
      frst_q <= 1'b0;
    end else begin
      o_rvalid <= rd_take;
      frst_q <= ~i_flash_reset;
      if (rd_take) begin
        o_rdata <= bus.shared_addr_data_bus;
      end
    end
  end

  assign o_busy = st_q != mbp_pkg::H_IDLE;
  assign o_done = st_q == mbp_pkg::H_END;

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign active = st_q != mbp_pkg::H_IDLE;
  assign bus.addr_valid_n = st_q != mbp_pkg::H_ADDR;
  assign bus.upper_addr_inputs = addr_q[23:16];
  // the turn cycle leaves the bus undriven before the read enable
  assign bus.host_dq_oe = (st_q == mbp_pkg::H_ADDR) |
                          (write_q & (st_q == mbp_pkg::H_WR | st_q == mbp_pkg::H_END));
  assign bus.host_dq_o = (st_q == mbp_pkg::H_ADDR) ? addr_q[15:0] : wdata_q;
  assign bus.burst_clk = bclk_q;
  assign bus.oe_n = st_q != mbp_pkg::H_RD;
  assign bus.we_n = st_q != mbp_pkg::H_WR;
  assign bus.flash_ce_n = ~(active & ~psram_q);
  assign bus.psram_ce_n = ~(active & psram_q);
  assign bus.flash_rst_n = frst_q;
  assign bus.psram_ctrl_reg_select = cre_q;
  assign bus.psram_low_byte_n = ben_n_q[0];
  assign bus.psram_high_byte_n = ben_n_q[1];
endmodule : mbp_host_end

`default_nettype wire

// file: verification/mbp_bus_sva.sv
// checker: pin-level properties of the shared burst memory bus
`default_nettype none

module mbp_bus_sva (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // pins
  input wire logic addr_valid_n,
  input wire logic host_dq_oe,
  input wire logic dev_dq_oe,
  input wire logic [mbp_pkg::DQ_W-1:0] shared_addr_data_bus,
  input wire logic burst_clk,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic flash_ce_n,
  input wire logic psram_ce_n,
  input wire logic rdy_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_one_bus_driver: assert property (!(host_dq_oe && dev_dq_oe))
    else $error("both ends drive the shared bus");
  a_strobe_host_drives: assert property (!addr_valid_n |-> host_dq_oe)
    else $error("address strobe low without host driving the bus");
  a_addr_held: assert property (!addr_valid_n && $past(!addr_valid_n)
    |-> $stable(shared_addr_data_bus)) else $error("address moved under strobe");
  a_dev_quiet_strobe: assert property (dev_dq_oe |-> addr_valid_n && !oe_n && we_n)
    else $error("device drives without a read phase");
  a_oe_release: assert property ($rose(oe_n) |-> !dev_dq_oe)
    else $error("device kept driving after output enable rose");
  a_ce_release: assert property (flash_ce_n && psram_ce_n |-> !dev_dq_oe && !rdy_oe)
    else $error("device drives with no die selected");
  a_clk_still: assert property ((flash_ce_n && psram_ce_n) || !we_n |-> !burst_clk)
    else $error("burst clock moves outside a burst");
  a_clk_rate: assert property ($rose(burst_clk) |=> (!$rose(burst_clk)) [*7])
    else $error("burst clock too fast");
  a_write_data: assert property (!we_n |-> addr_valid_n && host_dq_oe && oe_n)
    else $error("write strobe without host data");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_burst_capture: cover property ($rose(burst_clk) && !addr_valid_n);
  c_dev_drive: cover property ($rose(dev_dq_oe));
  c_write: cover property ($fell(we_n));
endmodule : mbp_bus_sva

`default_nettype wire

// file: verification/muxed_burst_memory_pin_interface_bench.sv
// bench: host end and device end joined through the shared pin interface
`default_nettype none

`define CHK(nm, exp, got) begin samples_checked++; if ((exp) !== (got)) begin \
  num_errors++; $display("BAD %s expected %h seen %h", nm, exp, got); end end

module muxed_burst_memory_pin_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk, i_rst_b, req, wr, ps, bu, ctl, freset, frl, pwl, rdy_seen;
  logic [3:0] len;
  logic [23:0] addr;
  logic [15:0] wd, rdata, fcfg, pcfg;
  logic [1:0] ben, vpp;
  logic busy, rvalid, done, fbusy, ubyp;
  logic [15:0] rq[$];
  int num_errors, samples_checked;

  // ----------------------------------------
  // ends and checker
  // ----------------------------------------
  mbp_bus_if bus ();
  mbp_host_end u_mbp_host_end (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req), .i_write(wr),
    .i_psram(ps), .i_burst(bu), .i_len(len), .i_addr(addr), .i_wdata(wd), .i_ctrl_reg(ctl),
    .i_byte_en_n(ben), .i_flash_reset(freset), .i_flash_rdy_low(frl),
    .i_psram_wait_low(pwl), .o_busy(busy), .o_rvalid(rvalid), .o_rdata(rdata),
    .o_done(done), .bus(bus));
  mbp_device_end u_mbp_device_end (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_vpp_level(vpp),
    .o_flash_busy(fbusy), .o_unlock_bypass(ubyp), .o_flash_cfg(fcfg),
    .o_psram_cfg(pcfg), .bus(bus));
  mbp_bus_sva u_mbp_bus_sva (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .addr_valid_n(bus.addr_valid_n), .host_dq_oe(bus.host_dq_oe),
    .dev_dq_oe(bus.dev_dq_oe), .shared_addr_data_bus(bus.shared_addr_data_bus),
    .burst_clk(bus.burst_clk), .oe_n(bus.oe_n), .we_n(bus.we_n),
    .flash_ce_n(bus.flash_ce_n), .psram_ce_n(bus.psram_ce_n), .rdy_oe(bus.rdy_oe));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic xfer(input logic w, p, b, c, input logic [3:0] n, input logic [23:0] a,
                      input logic [15:0] d);
    bit fin;
    fin = 0;
    rq.delete();
    rdy_seen = 1'hx;
    @(posedge i_clk);
    req <= 1'h1; wr <= w; ps <= p; bu <= b; ctl <= c; len <= n; addr <= a; wd <= d;
    @(posedge i_clk);
    req <= 1'h0;
    // data is taken mid-cycle so pulses and registers have settled
    for (int k = 0; k < 400 && !fin; k++) begin
      @(negedge i_clk);
      if (!(bus.flash_ce_n && bus.psram_ce_n)) rdy_seen = bus.rdy_wait;
      if (rvalid === 1'h1) rq.push_back(rdata);
      if (done === 1'h1) fin = 1;
    end
    if (!fin) `CHK("done", 1'h1, 1'h0)
    // the edge that closes the transfer lands configs, busy and arrays; look after it
    @(negedge i_clk);
    `CHK("host idle", 1'h0, busy)
    `CHK("bus released", 1'h0, bus.host_dq_oe)
  endtask : xfer

  task automatic wait_flash;
    for (int k = 0; k < 60 && fbusy !== 1'h0; k++) @(negedge i_clk);
    `CHK("flash idle", 1'h0, fbusy)
  endtask : wait_flash

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_psram_async;
    @(posedge i_clk) ben <= 2'h0;
    xfer(1'h1, 1'h1, 1'h0, 1'h0, 4'h0, 24'h000003, 16'hA5C3);
    xfer(1'h0, 1'h1, 1'h0, 1'h0, 4'h0, 24'h000003, 16'h0000);
    `CHK("psram word", 16'hA5C3, rq[0])
    `CHK("psram wait", 1'h0, rdy_seen)
    @(posedge i_clk) ben <= 2'h2;
    xfer(1'h1, 1'h1, 1'h0, 1'h0, 4'h0, 24'h000003, 16'h1234);
    @(posedge i_clk) ben <= 2'h0;
    xfer(1'h0, 1'h1, 1'h0, 1'h0, 4'h0, 24'h000003, 16'h0000);
    `CHK("psram low lane", 16'hA534, rq[0])
  endtask : t_psram_async

  task automatic t_flash_prog;
    @(posedge i_clk) vpp <= mbp_pkg::VPP_NORM;
    xfer(1'h1, 1'h0, 1'h0, 1'h0, 4'h0, 24'h000005, 16'h0F0F);
    `CHK("flash busy", 1'h1, fbusy)
    wait_flash();
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 4'h0, 24'h000005, 16'h0000);
    `CHK("flash word", 16'h0F0F, rq[0])
    `CHK("flash ready", 1'h1, rdy_seen)
    @(posedge i_clk) vpp <= mbp_pkg::VPP_LOW;
    repeat (4) @(posedge i_clk);
    xfer(1'h1, 1'h0, 1'h0, 1'h0, 4'h0, 24'h000005, 16'hFFFF);
    wait_flash();
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 4'h0, 24'h000005, 16'h0000);
    `CHK("flash locked", 16'h0F0F, rq[0])
    @(posedge i_clk) vpp <= mbp_pkg::VPP_HH;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("unlock bypass", 1'h1, ubyp)
    @(posedge i_clk) vpp <= mbp_pkg::VPP_NORM;
    repeat (4) @(posedge i_clk);
  endtask : t_flash_prog

  task automatic t_flash_cfg;
    xfer(1'h1, 1'h0, 1'h0, 1'h0, 4'h0, mbp_pkg::FCFG_ADDR, 16'h8000);
    wait_flash();
    `CHK("flash cfg", 16'h8000, fcfg)
    @(posedge i_clk) frl <= 1'h1;
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 4'h0, 24'h000005, 16'h0000);
    `CHK("ready low", 1'h0, rdy_seen)
    @(posedge i_clk);
    freset <= 1'h1;
    frl <= 1'h0;
    repeat (3) @(posedge i_clk);
    freset <= 1'h0;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("cfg after reset", 16'h8400, fcfg)
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 4'h0, 24'h000005, 16'h0000);
    `CHK("array read", 16'h0F0F, rq[0])
    // flash in burst mode with active low ready, so the flash side of the line is exercised
    xfer(1'h1, 1'h0, 1'h0, 1'h0, 4'h0, mbp_pkg::FCFG_ADDR, 16'h0000);
    @(posedge i_clk) frl <= 1'h1;
    xfer(1'h0, 1'h0, 1'h1, 1'h0, 4'h0, 24'h000005, 16'h0000);
    `CHK("flash burst count", 1, rq.size())
    `CHK("flash burst word", 16'h0F0F, rq[0])
    `CHK("flash burst ready", 1'h0, rdy_seen)
  endtask : t_flash_cfg

  task automatic t_psram_burst;
    for (int i = 0; i < 4; i++)
      xfer(1'h1, 1'h1, 1'h0, 1'h0, 4'h0, 24'h000008 + 24'(i), 16'hB000 + 16'(i));
    // burst mode and active low wait, so the psram line reads high when valid while the flash line reads low
    xfer(1'h1, 1'h1, 1'h0, 1'h1, 4'h0, 24'h000000, 16'h0000);
    `CHK("psram cfg", 16'h0000, pcfg)
    @(posedge i_clk) pwl <= 1'h1;
    xfer(1'h0, 1'h1, 1'h1, 1'h0, 4'h3, 24'h000008, 16'h0000);
    `CHK("burst count", 4, rq.size())
    `CHK("burst first", 16'hB000, rq[0])
    for (int i = 1; i < 4; i++) `CHK("burst word", 16'hB000 + 16'(i), rq[i])
  endtask : t_psram_burst

  task automatic print_verdict;
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    i_rst_b = 1'h0; req = 1'h0; wr = 1'h0; ps = 1'h0; bu = 1'h0; ctl = 1'h0;
    freset = 1'h0; frl = 1'h0; pwl = 1'h0; len = 4'h0; addr = 24'h000000;
    wd = 16'h0000; ben = 2'h0; vpp = mbp_pkg::VPP_NORM;
    num_errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'h1;
    repeat (2) @(posedge i_clk);
    t_psram_async();
    t_flash_prog();
    t_flash_cfg();
    t_psram_burst();
    print_verdict();
  end
endmodule : muxed_burst_memory_pin_interface_bench

`undef CHK
`default_nettype wire
